// file: drive_state_pkg.sv
package drive_state_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] ADDR_COMMAND = 16'h6040;
  localparam logic [15:0] ADDR_STATE = 16'h6041;
  localparam logic [15:0] COMMAND_RESET = 16'h0000;
  // ----------------------------------------
  // Command word fields
  // ----------------------------------------
  localparam int CB_SWITCH_ON = 0;
  localparam int CB_VOLTAGE = 1;
  localparam int CB_QSTOP_N = 2;
  localparam int CB_ENABLE_OP = 3;
  localparam int CB_MODE4 = 4;
  localparam int CB_MODE5 = 5;
  localparam int CB_MODE6 = 6;
  localparam int CB_FAULT_RESET = 7;
  localparam int CB_HALT = 8;
  // ----------------------------------------
  // State word fields
  // ----------------------------------------
  localparam int SB_FAULT = 3;
  localparam int SB_QSTOP = 5;
  localparam int SB_DISABLED = 6;
  localparam int SB_WARNING = 7;
  localparam int SB_REMOTE = 9;
  localparam int SB_TARGET = 10;
  localparam logic [3:0] LOW_NOT_READY = 4'h0;
  localparam logic [3:0] LOW_READY = 4'h1;
  localparam logic [3:0] LOW_SWITCHED_ON = 4'h3;
  localparam logic [3:0] LOW_ENABLED = 4'h7;
  localparam logic [3:0] LOW_FAULT_REACT = 4'hF;
  localparam logic [3:0] LOW_FAULT = 4'h8;
  // ----------------------------------------
  // Operating modes and panel codes
  // ----------------------------------------
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_HOMING = 2'h1;
  localparam logic [1:0] MODE_INTERP = 2'h2;
  localparam logic [1:0] MODE_VELOCITY = 2'h3;
  localparam logic [1:0] PANEL_RESET = 2'h0;
  localparam logic [1:0] PANEL_READY = 2'h1;
  localparam logic [1:0] PANEL_RUNNING = 2'h2;
  localparam logic [1:0] PANEL_FAULT = 2'h3;
  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_DISABLED = 8'h02,
    ST_READY = 8'h04,
    ST_SWITCHED_ON = 8'h08,
    ST_ENABLED = 8'h10,
    ST_QSTOP = 8'h20,
    ST_FAULT_REACT = 8'h40,
    ST_FAULT = 8'h80
  } drive_state_t;
endpackage : drive_state_pkg

// file: motion_trigger_if.sv
`timescale 1ns/1ps
`default_nettype none
interface motion_trigger_if;
  logic [15:0] command;
  logic [1:0] mode;
  logic enabled;
  logic start_target;
  logic immediate_update;
  logic relative_target;
  logic homing_start;
  logic homing_stop;
  modport decoder (input command, mode, enabled,
    output start_target, immediate_update, relative_target, homing_start, homing_stop);
  modport core (output command, mode, enabled,
    input start_target, immediate_update, relative_target, homing_start, homing_stop);
endinterface : motion_trigger_if
`default_nettype wire

// file: motion_trigger_decode.sv
`timescale 1ns/1ps
`default_nettype none
module motion_trigger_decode
  import drive_state_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Link to the state core
  motion_trigger_if.decoder trig
);
  typedef struct packed {
    logic last_bit4;
    logic start_target;
    logic immediate_update;
    logic relative_target;
    logic homing_start;
    logic homing_stop;
  } trig_state_t;

  trig_state_t cur;
  trig_state_t next_cur;
  logic bit4;
  logic rise4;
  logic fall4;

  assign bit4 = trig.command[CB_MODE4];
  assign rise4 = bit4 && !cur.last_bit4 && trig.enabled;
  assign fall4 = !bit4 && cur.last_bit4 && trig.enabled;

  always_comb begin
    next_cur = cur;
    next_cur.last_bit4 = bit4;
    next_cur.start_target = rise4 && (trig.mode == MODE_POSITION);
    next_cur.homing_start = rise4 && (trig.mode == MODE_HOMING);
    next_cur.homing_stop = fall4 && (trig.mode == MODE_HOMING);
    // Bits 5 and 6 mean nothing outside position mode
    next_cur.immediate_update = (trig.mode == MODE_POSITION) && trig.command[CB_MODE5];
    next_cur.relative_target = (trig.mode == MODE_POSITION) && trig.command[CB_MODE6];
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign trig.start_target = cur.start_target;
  assign trig.immediate_update = cur.immediate_update;
  assign trig.relative_target = cur.relative_target;
  assign trig.homing_start = cur.homing_start;
  assign trig.homing_stop = cur.homing_stop;

  property p_start_pulse;
    @(posedge ref_clk) disable iff (!resetn)
      (trig.mode == MODE_POSITION && trig.enabled && trig.command[CB_MODE4]
       && !$past(trig.command[CB_MODE4])) |=> trig.start_target;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("target start missed");

  property p_homing_stop;
    @(posedge ref_clk) disable iff (!resetn)
      trig.homing_stop |-> !trig.homing_start && $past(trig.mode) == MODE_HOMING;
  endproperty
  a_homing_stop: assert property (p_homing_stop) else $error("bad homing stop");

  property p_mode_bits;
    @(posedge ref_clk) disable iff (!resetn)
      $past(trig.mode) != MODE_POSITION |-> !trig.immediate_update && !trig.relative_target;
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("bits 5/6 used off mode");
endmodule : motion_trigger_decode
`default_nettype wire

// file: drive_state_control.sv
`timescale 1ns/1ps
`default_nettype none
module drive_state_control
  import drive_state_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Object access from the master
  input wire logic obj_write,
  input wire logic [15:0] obj_addr,
  input wire logic [15:0] obj_wdata,
  output logic [15:0] obj_rdata,
  // Drive side conditions, from pins
  input wire logic init_done,
  input wire logic hw_fault,
  input wire logic fault_report,
  input wire logic [11:0] fault_code,
  input wire logic warning,
  input wire logic stop_done,
  input wire logic target_reached,
  input wire logic [1:0] op_mode,
  // Outputs
  output logic motor_power,
  output logic [1:0] panel_mode,
  output logic [11:0] fault_code_indication,
  output logic ready_state_indication,
  output logic start_target,
  output logic immediate_update,
  output logic relative_target,
  output logic homing_start,
  output logic homing_stop
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] pins;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {init_done, hw_fault, fault_report, warning, stop_done, target_reached};
      sync_b <= sync_a;
    end
  end
  assign pins = sync_b;
  logic s_init;
  logic s_hwf;
  logic s_fault;
  logic s_warn;
  logic s_stop;
  logic s_tgt;
  assign {s_init, s_hwf, s_fault, s_warn, s_stop, s_tgt} = pins;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    drive_state_t st;
    logic [15:0] command;
    logic last_freset;
    logic [15:0] status;
    logic [11:0] code;
  } core_t;

  core_t cur;
  core_t next_cur;
  logic cmd_wr;
  logic [15:0] cw;
  logic on_b;
  logic volt_b;
  logic qs_n;
  logic en_b;
  logic freset_rise;
  logic any_fault;

  assign cmd_wr = obj_write && (obj_addr == ADDR_COMMAND);
  assign cw = cmd_wr ? obj_wdata : cur.command;
  // Command decode uses the freshly written word
  assign on_b = cw[CB_SWITCH_ON];
  assign volt_b = cw[CB_VOLTAGE];
  assign qs_n = cw[CB_QSTOP_N];
  assign en_b = cw[CB_ENABLE_OP];
  assign freset_rise = cw[CB_FAULT_RESET] && !cur.last_freset;
  assign any_fault = s_fault || s_hwf;

  function automatic logic [15:0] encode(input drive_state_t s, input logic w, input logic t);
    logic [15:0] v;
    v = '0;
    v[SB_WARNING] = w;
    v[SB_TARGET] = t;
    v[SB_REMOTE] = 1'b1;
    case (s)
      ST_NOT_READY: v[3:0] = LOW_NOT_READY;
      ST_DISABLED: begin
        v[3:0] = LOW_NOT_READY;
        v[SB_DISABLED] = 1'b1;
      end
      ST_READY: begin
        v[3:0] = LOW_READY;
        v[SB_QSTOP] = 1'b1;
      end
      ST_SWITCHED_ON: begin
        v[3:0] = LOW_SWITCHED_ON;
        v[SB_QSTOP] = 1'b1;
      end
      ST_ENABLED: begin
        v[3:0] = LOW_ENABLED;
        v[SB_QSTOP] = 1'b1;
      end
      ST_QSTOP: v[3:0] = LOW_ENABLED;
      ST_FAULT_REACT: v[3:0] = LOW_FAULT_REACT;
      ST_FAULT: v[3:0] = LOW_FAULT;
      default: v[3:0] = LOW_NOT_READY;
    endcase
    return v;
  endfunction : encode

  always_comb begin
    next_cur = cur;
    if (cmd_wr) begin
      next_cur.command = obj_wdata;
    end
    next_cur.last_freset = cw[CB_FAULT_RESET];
    // Transitions not listed keep the state as it is
    case (cur.st)
      ST_NOT_READY: begin
        if (s_fault) begin
          next_cur.st = ST_FAULT;
        end else if (s_init && !s_hwf) begin
          next_cur.st = ST_DISABLED;
        end
      end
      ST_DISABLED: begin
        if (any_fault) begin
          next_cur.st = ST_FAULT;
        end else if (cmd_wr && volt_b && qs_n && !on_b) begin
          next_cur.st = ST_READY;
        end
      end
      ST_READY: begin
        if (any_fault) begin
          next_cur.st = ST_FAULT_REACT;
        end else if (cmd_wr && (!volt_b || !qs_n)) begin
          next_cur.st = ST_DISABLED;
        end else if (cmd_wr && on_b && volt_b && qs_n && !en_b) begin
          next_cur.st = ST_SWITCHED_ON;
        end
      end
      ST_SWITCHED_ON: begin
        if (any_fault) begin
          next_cur.st = ST_FAULT_REACT;
        end else if (cmd_wr && (!volt_b || !qs_n)) begin
          next_cur.st = ST_DISABLED;
        end else if (cmd_wr && !on_b) begin
          next_cur.st = ST_READY;
        end else if (cmd_wr && on_b && en_b) begin
          next_cur.st = ST_ENABLED;
        end
      end
      ST_ENABLED: begin
        if (any_fault) begin
          next_cur.st = ST_FAULT_REACT;
        end else if (cmd_wr && volt_b && !qs_n) begin
          next_cur.st = ST_QSTOP;
        end else if (cmd_wr && !volt_b) begin
          next_cur.st = ST_DISABLED;
        end else if (cmd_wr && on_b && !en_b) begin
          next_cur.st = ST_SWITCHED_ON;
        end else if (cmd_wr && !on_b) begin
          next_cur.st = ST_READY;
        end
      end
      ST_QSTOP: begin
        if (any_fault) begin
          next_cur.st = ST_FAULT_REACT;
        end else if (s_stop) begin
          next_cur.st = ST_DISABLED;
        end
      end
      ST_FAULT_REACT: begin
        if (s_stop) begin
          next_cur.st = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (freset_rise && !any_fault) begin
          next_cur.st = ST_DISABLED;
        end
      end
      default: next_cur.st = ST_NOT_READY;
    endcase
    if (s_fault) begin
      next_cur.code = fault_code;
    end
    next_cur.status = encode(next_cur.st, s_warn, s_tgt);
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cur.st <= ST_NOT_READY;
      cur.command <= COMMAND_RESET;
      cur.last_freset <= 1'b0;
      cur.status <= 16'h0200;
      cur.code <= 12'h000;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Power follows the state only; command bits never reach the switch
  assign motor_power = (cur.st == ST_ENABLED) || (cur.st == ST_QSTOP)
    || (cur.st == ST_FAULT_REACT);
  assign obj_rdata = (obj_addr == ADDR_STATE) ? cur.status
    : (obj_addr == ADDR_COMMAND) ? cur.command : 16'h0000;
  always_comb begin
    case (cur.st)
      ST_NOT_READY: panel_mode = PANEL_RESET;
      ST_ENABLED: panel_mode = PANEL_RUNNING;
      ST_FAULT, ST_FAULT_REACT: panel_mode = PANEL_FAULT;
      default: panel_mode = PANEL_READY;
    endcase
  end
  assign ready_state_indication = (panel_mode == PANEL_READY);
  assign fault_code_indication = cur.code;

  motion_trigger_if trig_bus ();
  assign trig_bus.command = cur.command;
  assign trig_bus.mode = op_mode;
  assign trig_bus.enabled = (cur.st == ST_ENABLED);
  assign start_target = trig_bus.start_target;
  assign immediate_update = trig_bus.immediate_update;
  assign relative_target = trig_bus.relative_target;
  assign homing_start = trig_bus.homing_start;
  assign homing_stop = trig_bus.homing_stop;
  motion_trigger_decode u_trig (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .trig(trig_bus.decoder)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_enable_seq;
    cur.st == ST_SWITCHED_ON && cmd_wr && obj_wdata[3:0] == 4'hF && !any_fault;
  endsequence
  property p_enable;
    @(posedge ref_clk) disable iff (!resetn) s_enable_seq |=> cur.st == ST_ENABLED;
  endproperty
  a_enable: assert property (p_enable) else $error("15 did not enable");
  property p_disable7;
    @(posedge ref_clk) disable iff (!resetn)
      (cur.st == ST_ENABLED && cmd_wr && obj_wdata[3:0] == 4'h7 && !any_fault)
      |=> cur.st == ST_SWITCHED_ON;
  endproperty
  a_disable7: assert property (p_disable7) else $error("7 did not disable");
  property p_qstop;
    @(posedge ref_clk) disable iff (!resetn)
      (cur.st == ST_ENABLED && cmd_wr && obj_wdata[3:0] == 4'h2 && !any_fault)
      |=> cur.st == ST_QSTOP && motor_power;
  endproperty
  a_qstop: assert property (p_qstop) else $error("2 did not quick stop");
  property p_qstop_done;
    @(posedge ref_clk) disable iff (!resetn)
      (cur.st == ST_QSTOP && s_stop && !any_fault) |=> cur.st == ST_DISABLED;
  endproperty
  a_qstop_done: assert property (p_qstop_done) else $error("no auto disable");
  property p_power;
    @(posedge ref_clk) disable iff (!resetn)
      motor_power |-> cur.status[2:0] == 3'h7;
  endproperty
  a_power: assert property (p_power) else $error("power in wrong state");
  property p_status;
    @(posedge ref_clk) disable iff (!resetn)
      cur.st == ST_FAULT |-> cur.status[3:0] == LOW_FAULT && !motor_power;
  endproperty
  a_status: assert property (p_status) else $error("fault pattern wrong");
  property p_hold;
    @(posedge ref_clk) disable iff (!resetn)
      (cur.st == ST_DISABLED && !any_fault && !cmd_wr) |=> $stable(cur.st);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without cause");
  property p_freset;
    @(posedge ref_clk) disable iff (!resetn)
      (cur.st == ST_FAULT && freset_rise && !any_fault) |=> cur.st == ST_DISABLED;
  endproperty
  a_freset: assert property (p_freset) else $error("fault reset ignored");
endmodule : drive_state_control
`default_nettype wire

// file: master_station_model.sv
`timescale 1ns/1ps
`default_nettype none
module master_station_model (
  // Clock
  input wire logic ref_clk,
  // Object access towards the drive
  output logic obj_write,
  output logic [15:0] obj_addr,
  output logic [15:0] obj_wdata
);
  initial begin
    obj_write = 1'b0;
    obj_addr = 16'h6041;
    obj_wdata = 16'h0000;
  end

  // ----------------------------------------
  // Object writes
  // ----------------------------------------
  task automatic write_obj(input logic [15:0] addr, input logic [15:0] data);
    @(negedge ref_clk);
    obj_write = 1'b1;
    obj_addr = addr;
    obj_wdata = data;
    @(negedge ref_clk);
    obj_write = 1'b0;
    obj_addr = 16'h6041;
    // Released data shows the inverse so a stale value cannot pass for a write
    obj_wdata = ~data;
  endtask : write_obj

  task automatic select(input logic [15:0] addr);
    obj_addr = addr;
  endtask : select

  task automatic enable_drive();
    write_obj(16'h6040, 16'h0006);
    write_obj(16'h6040, 16'h0007);
    write_obj(16'h6040, 16'h000F);
  endtask : enable_drive

  task automatic disable_op();
    write_obj(16'h6040, 16'h0007);
  endtask : disable_op

  task automatic quick_stop();
    write_obj(16'h6040, 16'h0002);
  endtask : quick_stop
endmodule : master_station_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import drive_state_pkg::*;
  typedef struct {
    logic [1:0] kind;
    logic [15:0] exp;
    logic [15:0] mask;
  } note_t;
  logic ref_clk, resetn, obj_write, init_done, hw_fault, fault_report;
  logic warning, stop_done, target_reached, motor_power, ready_state_indication;
  logic start_target, immediate_update, relative_target, homing_start, homing_stop;
  logic [15:0] obj_addr, obj_wdata, obj_rdata, flags;
  logic [11:0] fault_code, fault_code_indication, code;
  logic [1:0] op_mode, panel_mode;
  int error_cnt, checked;
  note_t notes[$];
  note_t n;
  event look;
  logic [1:0] trig_mode [6] = '{MODE_POSITION, MODE_POSITION, MODE_HOMING, MODE_HOMING,
    MODE_INTERP, MODE_VELOCITY};
  logic [15:0] trig_cmd [6] = '{16'h001F, 16'h006F, 16'h007F, 16'h000F, 16'h001F, 16'h000F};
  logic [15:0] trig_flag [6] = '{16'h0010, 16'h000C, 16'h0002, 16'h0001, 16'h0000, 16'h0000};
  assign flags = {7'h00, motor_power, panel_mode, ready_state_indication, start_target,
    immediate_update, relative_target, homing_start, homing_stop};

  master_station_model master_station_model_i (.ref_clk(ref_clk), .obj_write(obj_write),
    .obj_addr(obj_addr), .obj_wdata(obj_wdata));
  drive_state_control drive_state_control_i (.ref_clk(ref_clk), .resetn(resetn),
    .obj_write(obj_write), .obj_addr(obj_addr), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .init_done(init_done), .hw_fault(hw_fault), .fault_report(fault_report),
    .fault_code(fault_code), .warning(warning), .stop_done(stop_done),
    .target_reached(target_reached), .op_mode(op_mode), .motor_power(motor_power),
    .panel_mode(panel_mode), .fault_code_indication(fault_code_indication),
    .ready_state_indication(ready_state_indication), .start_target(start_target),
    .immediate_update(immediate_update), .relative_target(relative_target),
    .homing_start(homing_start), .homing_stop(homing_stop));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Reporting and comparison
  // ----------------------------------------
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("Error t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_flags(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    checked++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("Error t=%0t flags got %h exp %h", $time, got, exp);
    end
  endtask : cmp_flags

  // Watcher: results are taken in the order the driver noted them
  initial begin
    forever begin
      @(look);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        if (n.kind == 2'd1) cmp_flags(flags, n.exp, n.mask);
        else if (n.kind == 2'd2) cmp_word({4'h0, fault_code_indication}, n.exp, n.mask);
        else cmp_word(obj_rdata, n.exp, n.mask);
      end
    end
  end

  // ----------------------------------------
  // Driver helpers
  // ----------------------------------------
  task automatic note(input logic [1:0] kind, input logic [15:0] exp, input logic [15:0] mask);
    notes.push_back('{kind, exp, mask});
    #1;
    ->look;
    // Hand back on a falling edge so the next stimulus lands there too
    @(negedge ref_clk);
  endtask : note

  task automatic cmd(input logic [15:0] v);
    master_station_model_i.write_obj(ADDR_COMMAND, v);
    @(negedge ref_clk);
  endtask : cmd

  // Synced inputs take a few cycles, so poll the state word under a bound
  task automatic wait_word(input logic [15:0] exp, input logic [15:0] mask);
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      if ((obj_rdata & mask) === exp) break;
    end
    if (i == 40) begin
      error_cnt++;
      $display("Error t=%0t wait got %h exp %h", $time, obj_rdata, exp);
      complete_run();
    end else begin
      note(2'd0, exp, mask);
    end
  endtask : wait_word

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    init_done = 1'b0;
    hw_fault = 1'b1;
    fault_report = 1'b0;
    fault_code = 12'h000;
    warning = 1'b0;
    stop_done = 1'b0;
    target_reached = 1'b0;
    op_mode = MODE_POSITION;
    error_cnt = 0;
    checked = 0;
    void'($urandom(32'h71ce));
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    note(2'd0, 16'h0200, 16'hFFFF);
    note(2'd1, 16'h0000, 16'h01E0);
    master_station_model_i.select(ADDR_COMMAND);
    note(2'd0, COMMAND_RESET, 16'hFFFF);
    master_station_model_i.select(16'h1234);
    note(2'd0, 16'h0000, 16'hFFFF);
    master_station_model_i.select(ADDR_STATE);
    // Init done but hardware fault still present: no progress
    init_done = 1'b1;
    repeat (6) @(negedge ref_clk);
    note(2'd0, 16'h0200, 16'hFFFF);
    hw_fault = 1'b0;
    wait_word(16'h0240, 16'hFFFF);
    note(2'd1, 16'h0060, 16'h01E0);
    warning = 1'b1;
    wait_word(16'h02C0, 16'hFFFF);
    target_reached = 1'b1;
    wait_word(16'h06C0, 16'hFFFF);
    warning = 1'b0;
    target_reached = 1'b0;
    wait_word(16'h0240, 16'hFFFF);
    cmd(16'h000F);
    note(2'd0, 16'h0240, 16'hFFFF);
    note(2'd1, 16'h0060, 16'h01E0);
    master_station_model_i.write_obj(ADDR_STATE, 16'($urandom()));
    @(negedge ref_clk);
    note(2'd0, 16'h0240, 16'hFFFF);
    master_station_model_i.enable_drive();
    @(negedge ref_clk);
    note(2'd0, 16'h0227, 16'hFFFF);
    note(2'd1, 16'h0180, 16'h01E0);
    master_station_model_i.disable_op();
    @(negedge ref_clk);
    note(2'd0, 16'h0223, 16'hFFFF);
    note(2'd1, 16'h0060, 16'h01E0);
    cmd(16'h000F);
    note(2'd0, 16'h0227, 16'hFFFF);
    for (int k = 0; k < 6; k++) begin
      op_mode = trig_mode[k];
      cmd(trig_cmd[k]);
      note(2'd1, trig_flag[k], 16'h001F);
    end
    op_mode = MODE_POSITION;
    master_station_model_i.quick_stop();
    @(negedge ref_clk);
    note(2'd0, 16'h0207, 16'hFFFF);
    note(2'd1, 16'h0160, 16'h01E0);
    stop_done = 1'b1;
    wait_word(16'h0240, 16'hFFFF);
    note(2'd1, 16'h0060, 16'h01E0);
    stop_done = 1'b0;
    master_station_model_i.enable_drive();
    @(negedge ref_clk);
    code = 12'($urandom());
    fault_code = code;
    fault_report = 1'b1;
    wait_word(16'h000F, 16'h004F);
    note(2'd1, 16'h01C0, 16'h01E0);
    stop_done = 1'b1;
    wait_word(16'h0008, 16'h004F);
    note(2'd1, 16'h00C0, 16'h01E0);
    note(2'd2, {4'h0, code}, 16'hFFFF);
    fault_report = 1'b0;
    stop_done = 1'b0;
    repeat (4) @(negedge ref_clk);
    cmd(16'h0080);
    note(2'd0, 16'h0240, 16'hFFFF);
    cmd(16'h0006);
    note(2'd0, 16'h0221, 16'hFFFF);
    // Dropping voltage from ready falls back to switch-on-disabled
    cmd(16'h0000);
    note(2'd0, 16'h0240, 16'hFFFF);
    // Restart in mid-run: reset indication first, then ready again
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    note(2'd0, 16'h0200, 16'hFFFF);
    note(2'd1, 16'h0000, 16'h01FF);
    resetn = 1'b1;
    wait_word(16'h0240, 16'hFFFF);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
